// ### temp_sense_pkg.sv
/*
  Shared constants and types for the temperature and battery sense readout.
  Assumes a 20 MHz system clock; conversion slot lengths are derived from it.
*/
package temp_sense_pkg;
  // Register offsets.
  localparam logic [7:0] CFG_ONE_ADDR = 8'h00;
  localparam logic [7:0] CFG_THREE_ADDR = 8'h07;
  localparam logic [7:0] LOCAL_TEMP_ADDR = 8'h1F;
  // Field positions.
  localparam int START_BIT = 0;
  localparam int REF_HIGH_BIT = 2;
  localparam int PAIR2_AUX_BIT = 3;
  // Reset values.
  localparam logic [7:0] CFG_ONE_RESET = 8'h00;
  localparam logic [7:0] CFG_THREE_RESET = 8'h00;
  localparam logic [7:0] VALUE_RESET = 8'h00;
  // Averaging depth and its shift.
  localparam logic [3:0] AVG_LAST = 4'hF;
  localparam int AVG_SHIFT = 4;
  // Timing, in nanoseconds, and derived cycle counts.
  localparam int CLK_PERIOD_NS = 50;
  localparam int ANALOG_SLOT_NS = 711000;
  localparam int REMOTE_SLOT_NS = 2140000;
  localparam int ANALOG_SLOT_CYC = ANALOG_SLOT_NS / CLK_PERIOD_NS;
  localparam int REMOTE_SLOT_CYC = REMOTE_SLOT_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    CH_REMOTE1,
    CH_REMOTE2,
    CH_AUX8,
    CH_AUX9,
    CH_BATTERY,
    CH_LOCAL
  } channel_e;

  typedef enum logic {
    ST_IDLE,
    ST_CONVERT
  } state_e;
endpackage

// ### sample_averager.sv
/*
  Accumulates sixteen signed byte samples and delivers their mean.
  Assumes samples arrive as single-cycle strobes on the same clock.
*/
`timescale 1ns/100ps
module sample_averager
  import temp_sense_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Sample side.
  input wire logic clear,
  input wire logic sampleValid,
  input wire logic [7:0] sample,
  // Result side.
  output logic [7:0] avgValue,
  output logic avgValid,
  output logic [3:0] sampleCount
);
  logic signed [11:0] sum;
  logic signed [11:0] next_sum;
  logic signed [11:0] total;
  logic [3:0] next_sampleCount;
  logic [7:0] next_avgValue;
  logic next_avgValid;

  always_comb begin
    total = sum + {{4{sample[7]}}, sample};
    next_sum = sum;
    next_sampleCount = sampleCount;
    next_avgValue = avgValue;
    next_avgValid = 1'b0;
    if (clear) begin
      next_sum = '0;
      next_sampleCount = '0;
    end else if (sampleValid) begin
      if (sampleCount == AVG_LAST) begin
        // Arithmetic shift keeps the two's-complement sign of the mean.
        next_avgValue = 8'(total >>> AVG_SHIFT);
        next_avgValid = 1'b1;
        next_sum = '0;
        next_sampleCount = '0;
      end else begin
        next_sum = total;
        next_sampleCount = sampleCount + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sum <= '0;
      sampleCount <= '0;
      avgValue <= VALUE_RESET;
      avgValid <= 1'b0;
    end else begin
      sum <= next_sum;
      sampleCount <= next_sampleCount;
      avgValue <= next_avgValue;
      avgValid <= next_avgValid;
    end
  end

  // Sixteen samples per mean.
  property p_sixteenSamples;
    @(posedge clk_sys) disable iff (!nrst)
    avgValid |-> $past(sampleCount) == AVG_LAST && $past(sampleValid) && !$past(clear);
  endproperty
  a_sixteenSamples: assert property (p_sixteenSamples) else $error("Mean without 16 samples.");
endmodule

// ### temp_sense_readout.sv
/*
  Sequences battery, diode and on-chip temperature conversions and holds results.
  Assumes an on-chip converter on the same clock presenting adcSample continuously.
*/
`timescale 1ns/100ps
// Function
// - The battery divider leg is connected only during a battery conversion slot.
// - Channels are converted round-robin, each result normally the mean of 16 samples.
// - The battery reading is one unaveraged conversion lasting one analog slot.
// - Bit 2 of config_three selects the high reference level when set.
// - Each on-chip temperature mean is stored as a signed byte in local_temp_value.
// - Temperatures are one degree per count from -128 to +127.
// - Bit 3 of config_one makes the second pair a diode input when 0, aux inputs when 1.
// - The first diode pair is always a remote temperature channel.
// - Remote conversions alternate base and multiplied bias and use the voltage difference.
// - Remote results are 8-bit two's-complement means of 16 measurements.
// - A remote conversion slot is given 2.14 ms.
// - Stored temperatures use 80h for -128, 00h for zero and 7Fh for +127.
// - Setting start in config_one runs conversions until software clears it.
// - The second pair is converted both ways every cycle; only the matching result is kept.
module temp_sense_readout
  import temp_sense_pkg::*;
#(
  parameter logic [15:0] ANALOG_SLOT_CYCLES = 16'(ANALOG_SLOT_CYC),
  parameter logic [15:0] REMOTE_SLOT_CYCLES = 16'(REMOTE_SLOT_CYC)
)(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Converter side.
  input wire logic [7:0] adcSample,
  output temp_sense_pkg::channel_e adcChannel,
  output logic biasHigh,
  output logic batteryLegConnect,
  output logic refHighSel,
  output logic measuring,
  // Results.
  output logic [7:0] remote1Temp,
  output logic [7:0] remote2Temp,
  output logic [7:0] auxAnalogInputEight,
  output logic [7:0] auxAnalogInputNine,
  output logic [7:0] batteryValue
);
  localparam logic [15:0] REMOTE_HALF = REMOTE_SLOT_CYCLES >> 1;

  state_e state, next_state;
  channel_e next_adcChannel, resultChannel, next_resultChannel;
  logic [15:0] slotCnt, next_slotCnt;
  logic [7:0] cfgOne, next_cfgOne, cfgThree, next_cfgThree;
  logic [7:0] localTemp, next_localTemp, lowSample, next_lowSample;
  logic [7:0] next_regRdData, next_remote1Temp, next_remote2Temp;
  logic [7:0] next_aux8, next_aux9, next_batteryValue;
  logic [7:0] sampleToAvg, avgValue;
  logic [3:0] sampleCount;
  logic sampleValid, avgClear, avgValid, isRemote, slotEnd;

  assign isRemote = adcChannel == CH_REMOTE1 || adcChannel == CH_REMOTE2;
  assign slotEnd = state == ST_CONVERT && slotCnt == 16'h0000;
  assign measuring = state == ST_CONVERT;
  // Battery leg gating.
  assign batteryLegConnect = measuring && adcChannel == CH_BATTERY;
  // Reference level select.
  assign refHighSel = cfgThree[REF_HIGH_BIT];
  // Bias alternation: base current first half, multiplied current second half.
  assign biasHigh = measuring && isRemote && slotCnt < REMOTE_HALF;

  sample_averager u_avg (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clear(avgClear),
    .sampleValid(sampleValid),
    .sample(sampleToAvg),
    .avgValue(avgValue),
    .avgValid(avgValid),
    .sampleCount(sampleCount)
  );

  always_comb begin
    next_cfgOne = cfgOne;
    next_cfgThree = cfgThree;
    if (regWrEn && regAddr == CFG_ONE_ADDR) begin
      next_cfgOne = regWrData;
    end else if (regWrEn && regAddr == CFG_THREE_ADDR) begin
      next_cfgThree = regWrData;
    end
    if (regAddr == CFG_ONE_ADDR) begin
      next_regRdData = cfgOne;
    end else if (regAddr == CFG_THREE_ADDR) begin
      next_regRdData = cfgThree;
    end else if (regAddr == LOCAL_TEMP_ADDR) begin
      next_regRdData = localTemp;
    end else begin
      next_regRdData = 8'h00;
    end
  end

  always_comb begin
    next_state = state;
    next_adcChannel = adcChannel;
    next_resultChannel = resultChannel;
    next_slotCnt = slotCnt;
    next_lowSample = lowSample;
    next_batteryValue = batteryValue;
    sampleValid = 1'b0;
    avgClear = 1'b0;
    // Remote samples are the multiplied-bias reading minus the base-bias one.
    sampleToAvg = isRemote ? 8'(adcSample - lowSample) : adcSample;
    case (state)
      ST_IDLE: begin
        avgClear = 1'b1;
        // Start bit launches the cycle from the first diode pair.
        if (cfgOne[START_BIT]) begin
          next_state = ST_CONVERT;
          next_adcChannel = CH_REMOTE1;
          next_slotCnt = REMOTE_SLOT_CYCLES - 16'h0001;
        end
      end
      ST_CONVERT: begin
        if (!cfgOne[START_BIT]) begin
          // Stop aborts at once so the battery leg is never left connected.
          next_state = ST_IDLE;
          avgClear = 1'b1;
        end else if (slotCnt != 16'h0000) begin
          next_slotCnt = slotCnt - 16'h0001;
          if (isRemote && slotCnt == REMOTE_HALF) begin
            next_lowSample = adcSample;
          end
        end else if (adcChannel == CH_BATTERY) begin
          // Single unaveraged battery conversion.
          next_batteryValue = adcSample;
          next_adcChannel = CH_LOCAL;
          next_slotCnt = ANALOG_SLOT_CYCLES - 16'h0001;
        end else begin
          sampleValid = 1'b1;
          // Sixteen slots per averaged channel, then move on round-robin.
          if (sampleCount == AVG_LAST) begin
            next_resultChannel = adcChannel;
            case (adcChannel)
              CH_REMOTE1: next_adcChannel = CH_REMOTE2;
              CH_REMOTE2: next_adcChannel = CH_AUX8;
              CH_AUX8: next_adcChannel = CH_AUX9;
              CH_AUX9: next_adcChannel = CH_BATTERY;
              default: next_adcChannel = CH_REMOTE1;
            endcase
          end
          // Remote slots get the longer diode conversion time.
          if (next_adcChannel == CH_REMOTE1 || next_adcChannel == CH_REMOTE2) begin
            next_slotCnt = REMOTE_SLOT_CYCLES - 16'h0001;
          end else begin
            next_slotCnt = ANALOG_SLOT_CYCLES - 16'h0001;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Values change only on a completed mean, never mid-accumulation.
  always_comb begin
    next_localTemp = localTemp;
    next_remote1Temp = remote1Temp;
    next_remote2Temp = remote2Temp;
    next_aux8 = auxAnalogInputEight;
    next_aux9 = auxAnalogInputNine;
    if (avgValid) begin
      case (resultChannel)
        // signed byte, one degree per count.
        CH_LOCAL: next_localTemp = avgValue;
        // averaged diode byte.
        // First pair is always a diode channel.
        CH_REMOTE1: next_remote1Temp = avgValue;
        // Both views of the second pair are converted; keep the configured one.
        CH_REMOTE2: if (!cfgOne[PAIR2_AUX_BIT]) next_remote2Temp = avgValue;
        CH_AUX8: if (cfgOne[PAIR2_AUX_BIT]) next_aux8 = avgValue;
        CH_AUX9: if (cfgOne[PAIR2_AUX_BIT]) next_aux9 = avgValue;
        default: next_localTemp = localTemp;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfgOne <= CFG_ONE_RESET;
      cfgThree <= CFG_THREE_RESET;
      regRdData <= 8'h00;
      state <= ST_IDLE;
      adcChannel <= CH_REMOTE1;
      resultChannel <= CH_REMOTE1;
      slotCnt <= 16'h0000;
      lowSample <= VALUE_RESET;
      batteryValue <= VALUE_RESET;
      localTemp <= VALUE_RESET;
      remote1Temp <= VALUE_RESET;
      remote2Temp <= VALUE_RESET;
      auxAnalogInputEight <= VALUE_RESET;
      auxAnalogInputNine <= VALUE_RESET;
    end else begin
      cfgOne <= next_cfgOne;
      cfgThree <= next_cfgThree;
      regRdData <= next_regRdData;
      state <= next_state;
      adcChannel <= next_adcChannel;
      resultChannel <= next_resultChannel;
      slotCnt <= next_slotCnt;
      lowSample <= next_lowSample;
      batteryValue <= next_batteryValue;
      localTemp <= next_localTemp;
      remote1Temp <= next_remote1Temp;
      remote2Temp <= next_remote2Temp;
      auxAnalogInputEight <= next_aux8;
      auxAnalogInputNine <= next_aux9;
    end
  end

  property p_legIdle;
    @(posedge clk_sys) disable iff (!nrst)
    $rose(batteryLegConnect)
      |-> slotCnt == ANALOG_SLOT_CYCLES - 16'h0001 && $past(adcChannel) == CH_AUX9;
  endproperty
  a_legIdle: assert property (p_legIdle) else $error("Battery leg connected outside slot.");

  property p_batterySingle;
    @(posedge clk_sys) disable iff (!nrst)
    $fell(batteryLegConnect) && $past(cfgOne[START_BIT]) |-> batteryValue == $past(adcSample);
  endproperty
  a_batterySingle: assert property (p_batterySingle) else $error("Battery not single sample.");

  property p_refSelect;
    @(posedge clk_sys) disable iff (!nrst)
    regWrEn && regAddr == CFG_THREE_ADDR |=> refHighSel == $past(regWrData[REF_HIGH_BIT]);
  endproperty
  a_refSelect: assert property (p_refSelect) else $error("Reference select wrong.");

  property p_localStore;
    @(posedge clk_sys) disable iff (!nrst)
    avgValid && resultChannel == CH_LOCAL |=> localTemp == $past(avgValue);
  endproperty
  a_localStore: assert property (p_localStore) else $error("Local temperature not stored.");

  property p_stop;
    @(posedge clk_sys) disable iff (!nrst)
    !cfgOne[START_BIT] |=> state == ST_IDLE ##1 !batteryLegConnect;
  endproperty
  a_stop: assert property (p_stop) else $error("Conversion did not stop.");

  property p_pairKeep;
    @(posedge clk_sys) disable iff (!nrst)
    avgValid && resultChannel == CH_REMOTE2 && cfgOne[PAIR2_AUX_BIT] |=> $stable(remote2Temp);
  endproperty
  a_pairKeep: assert property (p_pairKeep) else $error("Discarded diode result stored.");

  property p_onlyComplete;
    @(posedge clk_sys) disable iff (!nrst)
    !$stable(remote1Temp) |-> $past(avgValid) && $past(resultChannel) == CH_REMOTE1;
  endproperty
  a_onlyComplete: assert property (p_onlyComplete) else $error("Partial value stored.");

  property p_biasRemote;
    @(posedge clk_sys) disable iff (!nrst)
    $rose(biasHigh) |-> isRemote && slotCnt == REMOTE_HALF - 16'h0001;
  endproperty
  a_biasRemote: assert property (p_biasRemote) else $error("Bias step misplaced.");

  property p_remoteSlot;
    @(posedge clk_sys) disable iff (!nrst)
    slotEnd && cfgOne[START_BIT] && next_adcChannel == CH_REMOTE2
      |=> slotCnt == REMOTE_SLOT_CYCLES - 16'h0001;
  endproperty
  a_remoteSlot: assert property (p_remoteSlot) else $error("Remote slot length wrong.");

  c_battery: cover property (@(posedge clk_sys) disable iff (!nrst) $fell(batteryLegConnect));
  c_local: cover property (@(posedge clk_sys) disable iff (!nrst)
    avgValid && resultChannel == CH_LOCAL);
  c_stop: cover property (@(posedge clk_sys) disable iff (!nrst) $fell(measuring));
endmodule

// ### temp_diode_model.sv
/*
  Behavioural model of the analog side: two remote diodes, a backup battery,
  two aux inputs and the on-chip sensor, all seen through the converter output.
  Assumes the readout drives channel, bias and battery leg from the same clock.
*/
`timescale 1ns/100ps
module temp_diode_model #(
  parameter logic [7:0] REMOTE1_T = 8'h80,
  parameter logic [7:0] REMOTE2_T = 8'h7F,
  parameter logic [7:0] LOCAL_T = 8'hE7,
  parameter logic [7:0] BATTERY_V = 8'hA5,
  parameter logic [7:0] AUX8_V = 8'h11,
  parameter logic [7:0] AUX9_V = 8'h22
)(
  // Clock.
  input wire logic clk_sys,
  // Converter side.
  input wire temp_sense_pkg::channel_e adcChannel,
  input wire logic biasHigh,
  input wire logic batteryLegConnect,
  output logic [7:0] adcSample,
  // Board strapping of the second pin pair.
  input wire logic pairIsAux
);
  import temp_sense_pkg::*;
  // An offset on the base reading, so a readout that skips the difference is caught.
  localparam logic [7:0] JUNCTION_BASE = 8'h40;
  logic [7:0] idlePattern = 8'h00;
  logic [7:0] localCnt = 8'h00;

  always @(posedge clk_sys) begin
    idlePattern <= idlePattern + 8'h35;
    localCnt <= (adcChannel == CH_LOCAL) ? localCnt + 8'h01 : 8'h00;
  end

  always_comb begin
    case (adcChannel)
      CH_REMOTE1: adcSample = JUNCTION_BASE + (biasHigh ? REMOTE1_T : 8'h00);
      // Pins wired as aux inputs show no bias step, so a kept diode result reads zero.
      CH_REMOTE2: adcSample = JUNCTION_BASE + ((biasHigh && !pairIsAux) ? REMOTE2_T : 8'h00);
      CH_AUX8: adcSample = AUX8_V;
      CH_AUX9: adcSample = AUX9_V;
      CH_BATTERY: adcSample = batteryLegConnect ? BATTERY_V : idlePattern;
      // Alternate slots read one count above and below, so only a true mean matches.
      default: adcSample = localCnt[3] ? LOCAL_T + 8'h01 : LOCAL_T - 8'h01;
    endcase
  end
endmodule

// ### test_temp_sense_readout.sv
/*
  Self-checking testbench for the temperature and battery sense readout.
  Assumes short slot lengths of 8 and 16 cycles, so one round is 904 cycles.
*/
`timescale 1ns/100ps
module test_temp_sense_readout;
  import temp_sense_pkg::*;
  localparam logic [15:0] ANALOG_CYC = 16'h0008;
  localparam logic [15:0] REMOTE_CYC = 16'h0010;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic regWrEn = 1'b0;
  logic pairIsAux = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData, adcSample, remote1Temp, remote2Temp, aux8, aux9, batteryValue;
  logic [7:0] rd;
  channel_e adcChannel;
  logic biasHigh, batteryLegConnect, refHighSel, measuring;
  int n_errors = 0;
  int check_count = 0;
  int legCycles = 0;

  always #25 clk_sys = ~clk_sys;

  temp_sense_readout #(.ANALOG_SLOT_CYCLES(ANALOG_CYC), .REMOTE_SLOT_CYCLES(REMOTE_CYC)) dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdData(regRdData), .adcSample(adcSample),
    .adcChannel(adcChannel), .biasHigh(biasHigh), .batteryLegConnect(batteryLegConnect),
    .refHighSel(refHighSel), .measuring(measuring), .remote1Temp(remote1Temp),
    .remote2Temp(remote2Temp), .auxAnalogInputEight(aux8), .auxAnalogInputNine(aux9),
    .batteryValue(batteryValue));

  temp_diode_model partner_u (.clk_sys(clk_sys), .adcChannel(adcChannel),
    .biasHigh(biasHigh), .batteryLegConnect(batteryLegConnect), .adcSample(adcSample),
    .pairIsAux(pairIsAux));

  // Leg and bias must only appear in their own channel slots.
  always @(negedge clk_sys) begin
    if (batteryLegConnect === 1'b1) begin
      legCycles++;
      if (adcChannel !== CH_BATTERY) check8(8'h01, 8'h00);
    end
    if (biasHigh === 1'b1 && adcChannel !== CH_REMOTE1 && adcChannel !== CH_REMOTE2) begin
      check8(8'h01, 8'h00);
    end
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic waitCycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask

  task automatic regRead(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    waitCycles(2);
    d = regRdData;
  endtask

  task automatic test_reset();
    regRead(CFG_ONE_ADDR, rd); check8(rd, CFG_ONE_RESET);
    regRead(CFG_THREE_ADDR, rd); check8(rd, CFG_THREE_RESET);
    regRead(LOCAL_TEMP_ADDR, rd); check8(rd, VALUE_RESET);
    regRead(8'h3C, rd); check8(rd, 8'h00);
    check8({7'h00, measuring}, 8'h00);
    check8({7'h00, batteryLegConnect}, 8'h00);
    $display("test_reset done");
  endtask

  task automatic test_reference();
    regWrite(CFG_THREE_ADDR, 8'h04);
    waitCycles(1); check8({7'h00, refHighSel}, 8'h01);
    regRead(CFG_THREE_ADDR, rd); check8(rd, 8'h04);
    regWrite(CFG_THREE_ADDR, 8'h00);
    waitCycles(1); check8({7'h00, refHighSel}, 8'h00);
    regWrite(LOCAL_TEMP_ADDR, 8'h5A);
    regRead(LOCAL_TEMP_ADDR, rd); check8(rd, 8'h00);
    $display("test_reference done");
  endtask

  task automatic test_diode_round();
    legCycles = 0;
    regWrite(CFG_ONE_ADDR, 8'h01);
    waitCycles(2); check8({7'h00, measuring}, 8'h01);
    waitCycles(800);
    regRead(LOCAL_TEMP_ADDR, rd); check8(rd, 8'h00);
    waitCycles(130);
    check8(remote1Temp, 8'h80);
    check8(remote2Temp, 8'h7F);
    regRead(LOCAL_TEMP_ADDR, rd); check8(rd, 8'hE7);
    check8(batteryValue, 8'hA5);
    check8(aux8, 8'h00);
    check8(aux9, 8'h00);
    check8(8'(legCycles), ANALOG_CYC[7:0]);
    $display("test_diode_round done");
  endtask

  task automatic test_aux_round();
    regWrite(CFG_ONE_ADDR, 8'h09);
    pairIsAux <= 1'b1;
    waitCycles(930);
    check8(aux8, 8'h11);
    check8(aux9, 8'h22);
    check8(remote2Temp, 8'h7F);
    check8(remote1Temp, 8'h80);
    $display("test_aux_round done");
  endtask

  task automatic test_stop();
    regWrite(CFG_ONE_ADDR, 8'h00);
    waitCycles(2);
    check8({7'h00, measuring}, 8'h00);
    check8({7'h00, batteryLegConnect}, 8'h00);
    waitCycles(100);
    check8(remote1Temp, 8'h80);
    check8({7'h00, measuring}, 8'h00);
    $display("test_stop done");
  endtask

  task automatic conclude();
    $display("Checks made %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    test_reset();
    test_reference();
    test_diode_round();
    test_aux_round();
    test_stop();
    conclude();
  end

  // The planned sequence takes about 2010 cycles; this limit leaves ample slack.
  initial begin
    repeat (6000) @(posedge clk_sys);
    n_errors++;
    $display("FAIL t=%0t watchdog got=%h exp=%h", $time, 8'h01, 8'h00);
    conclude();
  end
endmodule
